// [design/rosb_map.vh]
// register map and field constants of the remap output select bank
`ifndef ROSB_MAP_VH
`define ROSB_MAP_VH

// register indices; byte address is four times the index
`define ROSB_IDX_PIN6   12'hEC6
`define ROSB_IDX_PIN7   12'hEC7
`define ROSB_IDX_PIN8   12'hEC8
`define ROSB_IDX_PIN9   12'hEC9
`define ROSB_IDX_PIN10  12'hECA
`define ROSB_IDX_PIN11  12'hECB
`define ROSB_IDX_PIN12  12'hECC
`define ROSB_IDX_PIN13  12'hECD
`define ROSB_IDX_PIN17  12'hED1
`define ROSB_IDX_PIN18  12'hED2
`define ROSB_IDX_PIN19  12'hED3
`define ROSB_IDX_PIN20  12'hED4
`define ROSB_IDX_PIN21  12'hED5
`define ROSB_IDX_PIN22  12'hED6
`define ROSB_IDX_LOCK   12'hEBF

// index field inside a byte address
`define ROSB_IDX_W      12
`define ROSB_IDX_LSB    2

// selector layout
`define ROSB_N_SEL      14
`define ROSB_N_BASE     10
`define ROSB_CODE_W     5
`define ROSB_CODE_RST   5'h00
`define ROSB_CODE_NONE  5'h00
`define ROSB_PAD_W      27

// lock register layout
`define ROSB_LOCK_BIT   0
`define ROSB_VIOL_BIT   1
`define ROSB_LOCK_PAD_W 30

// bus widths and responses
`define ROSB_DATA_W     32
`define ROSB_STRB_W     4
`define ROSB_RESP_OKAY  2'h0
`define ROSB_RESP_DEC   2'h3
`define ROSB_WORD_ZERO  32'h0000_0000

`endif

// [design/rosb_sel_reg.v]
// one output-select register with its lock gate and remap flag
`timescale 1ns/1ps
`include "rosb_map.vh"

module rosb_sel_reg #(
  parameter [`ROSB_IDX_W-1:0] P_IDX        = `ROSB_IDX_PIN6,
  parameter                   P_PRESENT    = 1,
  parameter [31:0]            P_VALID_MASK = 32'hFFFF_FFFE
) (
  input  wire                    i_clk,     // system clock
  input  wire                    i_rst_b,   // async reset, active low
  input  wire                    i_wr,      // write strobe, one cycle
  input  wire [`ROSB_IDX_W-1:0]  i_wr_idx,  // register index written
  input  wire [`ROSB_CODE_W-1:0] i_wr_code, // code being written
  input  wire                    i_lock,    // config_lock state
  output reg  [`ROSB_CODE_W-1:0] o_code,    // stored function code
  output reg                     o_remap    // pin taken by a function
);

  wire hit;

  // absent selectors never match, so they keep their reset value
  assign hit = (P_PRESENT != 0) && i_wr && (i_wr_idx == P_IDX);

  always @(posedge i_clk or negedge i_rst_b) begin
    if (!i_rst_b) begin
      o_code  <= `ROSB_CODE_RST;
      o_remap <= 1'b0;
    end else if (hit && !i_lock) begin
      o_code  <= i_wr_code;
      o_remap <= (i_wr_code != `ROSB_CODE_NONE) &&
                 P_VALID_MASK[i_wr_code];
    end
  end

endmodule // rosb_sel_reg

// [design/rosb_top.v]
// remap output select bank: selector registers behind an AXI4-Lite slave
//
// Local design decision: the AXI4-Lite interface to the registers.
`timescale 1ns/1ps
`include "rosb_map.vh"

module rosb_top #(
  parameter        P_ADDR_W     = 16,
  parameter        P_LARGE_PKG  = 1,
  parameter [31:0] P_VALID_MASK = 32'hFFFF_FFFE
) (
  input  wire                      I_REF_CLK,    // system clock
  input  wire                      I_RST_B,      // async reset, active low
  input  wire [P_ADDR_W-1:0]       I_AWADDR,     // write address
  input  wire                      I_AWVALID,    // write address valid
  output wire                      O_AWREADY,    // write address ready
  input  wire [`ROSB_DATA_W-1:0]   I_WDATA,      // write data
  input  wire [`ROSB_STRB_W-1:0]   I_WSTRB,      // write byte lanes
  input  wire                      I_WVALID,     // write data valid
  output wire                      O_WREADY,     // write data ready
  output wire [1:0]                O_BRESP,      // write response
  output wire                      O_BVALID,     // write response valid
  input  wire                      I_BREADY,     // write response ready
  input  wire [P_ADDR_W-1:0]       I_ARADDR,     // read address
  input  wire                      I_ARVALID,    // read address valid
  output wire                      O_ARREADY,    // read address ready
  output wire [`ROSB_DATA_W-1:0]   O_RDATA,      // read data
  output wire [1:0]                O_RRESP,      // read response
  output wire                      O_RVALID,     // read data valid
  input  wire                      I_RREADY,     // read data ready
  output wire [`ROSB_N_SEL*`ROSB_CODE_W-1:0] O_PIN_FUNC,  // codes per pin
  output wire [`ROSB_N_SEL-1:0]    O_PIN_REMAP,  // pin driven by function
  output wire                      O_CONFIG_LOCK // config_lock state
);

  ////////////////////////////////////////////////////////////////////////
  // selector index table

  function [`ROSB_IDX_W-1:0] idx_of;
    input integer n;
    begin
      case (n)
        0:       idx_of = `ROSB_IDX_PIN6;
        1:       idx_of = `ROSB_IDX_PIN7;
        2:       idx_of = `ROSB_IDX_PIN8;
        3:       idx_of = `ROSB_IDX_PIN9;
        4:       idx_of = `ROSB_IDX_PIN10;
        5:       idx_of = `ROSB_IDX_PIN11;
        6:       idx_of = `ROSB_IDX_PIN12;
        7:       idx_of = `ROSB_IDX_PIN13;
        8:       idx_of = `ROSB_IDX_PIN17;
        9:       idx_of = `ROSB_IDX_PIN18;
        10:      idx_of = `ROSB_IDX_PIN19;
        11:      idx_of = `ROSB_IDX_PIN20;
        12:      idx_of = `ROSB_IDX_PIN21;
        default: idx_of = `ROSB_IDX_PIN22;
      endcase
    end
  endfunction

  // pins 19 to 22 only on the large package
  function is_present;
    input integer n;
    begin
      is_present = (P_LARGE_PKG != 0) || (n < `ROSB_N_BASE);
    end
  endfunction

  function sel_hit;
    input [`ROSB_IDX_W-1:0] idx;
    integer k;
    begin
      sel_hit = 1'b0;
      for (k = 0; k < `ROSB_N_SEL; k = k + 1) begin
        if ((idx == idx_of(k)) && is_present(k)) begin
          sel_hit = 1'b1;
        end
      end
    end
  endfunction

  ////////////////////////////////////////////////////////////////////////
  // declarations

  reg                      awready_r;
  reg                      awready_nxt;
  reg                      aw_hold_r;
  reg                      aw_hold_nxt;
  reg  [`ROSB_IDX_W-1:0]   aw_idx_r;
  reg                      wready_r;
  reg                      wready_nxt;
  reg                      w_hold_r;
  reg                      w_hold_nxt;
  reg  [`ROSB_CODE_W+2:0]  w_byte_r;
  reg                      w_lane0_r;
  reg                      bvalid_r;
  reg                      bvalid_nxt;
  reg  [1:0]               bresp_r;
  reg                      arready_r;
  reg                      rvalid_r;
  reg                      rvalid_nxt;
  reg  [`ROSB_DATA_W-1:0]  rdata_r;
  reg  [`ROSB_DATA_W-1:0]  rdata_nxt;
  reg  [1:0]               rresp_r;
  reg  [1:0]               rresp_nxt;
  reg                      lock_r;
  reg                      viol_r;
  reg                      viol_nxt;
  integer                  i;

  wire                     aw_take;
  wire                     w_take;
  wire                     ar_take;
  wire                     do_wr;
  wire                     wr_stb;
  wire                     wr_sel;
  wire                     wr_lock;
  wire [`ROSB_IDX_W-1:0]   ar_idx;
  wire [`ROSB_N_SEL*`ROSB_CODE_W-1:0] code_all;
  wire [`ROSB_N_SEL-1:0]   remap_all;

  assign aw_take = I_AWVALID & awready_r;
  assign w_take  = I_WVALID & wready_r;
  assign ar_take = I_ARVALID & arready_r;
  assign ar_idx  = I_ARADDR[`ROSB_IDX_LSB+`ROSB_IDX_W-1:`ROSB_IDX_LSB];

  // the write lands once both halves are held and no response waits
  assign do_wr   = aw_hold_r & w_hold_r & ~bvalid_r;
  assign wr_stb  = do_wr & w_lane0_r;
  assign wr_sel  = wr_stb & sel_hit(aw_idx_r);
  assign wr_lock = wr_stb & (aw_idx_r == `ROSB_IDX_LOCK);

  ////////////////////////////////////////////////////////////////////////
  // selector registers

  genvar g;
  generate
    for (g = 0; g < `ROSB_N_SEL; g = g + 1) begin : g_sel
      rosb_sel_reg #(
        .P_IDX        (idx_of(g)),
        .P_PRESENT    (is_present(g)),
        .P_VALID_MASK (P_VALID_MASK)
      ) u_sel (
        .i_clk     (I_REF_CLK),
        .i_rst_b   (I_RST_B),
        .i_wr      (wr_stb),
        .i_wr_idx  (aw_idx_r),
        .i_wr_code (w_byte_r[`ROSB_CODE_W-1:0]),
        .i_lock    (lock_r),
        .o_code    (code_all[g*`ROSB_CODE_W +: `ROSB_CODE_W]),
        .o_remap   (remap_all[g])
      );
    end
  endgenerate

  ////////////////////////////////////////////////////////////////////////
  // write channel next state

  always @* begin
    aw_hold_nxt = aw_hold_r;
    w_hold_nxt  = w_hold_r;
    bvalid_nxt  = bvalid_r;
    if (do_wr) begin
      aw_hold_nxt = 1'b0;
      w_hold_nxt  = 1'b0;
      bvalid_nxt  = 1'b1;
    end else if (bvalid_r && I_BREADY) begin
      bvalid_nxt  = 1'b0;
    end
    if (aw_take) begin
      aw_hold_nxt = 1'b1;
    end
    if (w_take) begin
      w_hold_nxt = 1'b1;
    end
    // ready returns at completion, so a next address may wait beside bvalid
    awready_nxt = ~aw_hold_nxt;
    wready_nxt  = ~w_hold_nxt;
  end

  // a write refused by the lock is flagged; a new refusal beats the clear
  always @* begin
    viol_nxt = viol_r;
    if (wr_lock && w_byte_r[`ROSB_VIOL_BIT]) begin
      viol_nxt = 1'b0;
    end
    if (wr_sel && lock_r) begin
      viol_nxt = 1'b1;
    end
  end

  always @(posedge I_REF_CLK or negedge I_RST_B) begin
    if (!I_RST_B) begin
      awready_r <= 1'b0;
      wready_r  <= 1'b0;
      aw_hold_r <= 1'b0;
      w_hold_r  <= 1'b0;
      aw_idx_r  <= {`ROSB_IDX_W{1'b0}};
      w_byte_r  <= {(`ROSB_CODE_W+3){1'b0}};
      w_lane0_r <= 1'b0;
      bvalid_r  <= 1'b0;
      bresp_r   <= `ROSB_RESP_OKAY;
      lock_r    <= 1'b0;
      viol_r    <= 1'b0;
    end else begin
      awready_r <= awready_nxt;
      wready_r  <= wready_nxt;
      aw_hold_r <= aw_hold_nxt;
      w_hold_r  <= w_hold_nxt;
      bvalid_r  <= bvalid_nxt;
      viol_r    <= viol_nxt;
      if (aw_take) begin
        aw_idx_r <= I_AWADDR[`ROSB_IDX_LSB+`ROSB_IDX_W-1:`ROSB_IDX_LSB];
      end
      if (w_take) begin
        w_byte_r  <= I_WDATA[`ROSB_CODE_W+2:0];
        w_lane0_r <= I_WSTRB[0];
      end
      if (do_wr) begin
        // absent pins answer like holes in the map
        if (sel_hit(aw_idx_r) || (aw_idx_r == `ROSB_IDX_LOCK)) begin
          bresp_r <= `ROSB_RESP_OKAY;
        end else begin
          bresp_r <= `ROSB_RESP_DEC;
        end
      end
      // config_lock itself stays writable so software can release it
      if (wr_lock) begin
        lock_r <= w_byte_r[`ROSB_LOCK_BIT];
      end
    end
  end

  ////////////////////////////////////////////////////////////////////////
  // read channel

  always @* begin
    rdata_nxt = `ROSB_WORD_ZERO;
    rresp_nxt = `ROSB_RESP_DEC;
    for (i = 0; i < `ROSB_N_SEL; i = i + 1) begin
      if ((ar_idx == idx_of(i)) && is_present(i)) begin
        rdata_nxt = {{`ROSB_PAD_W{1'b0}},
                     code_all[i*`ROSB_CODE_W +: `ROSB_CODE_W]};
        rresp_nxt = `ROSB_RESP_OKAY;
      end
    end
    if (ar_idx == `ROSB_IDX_LOCK) begin
      rdata_nxt = {{`ROSB_LOCK_PAD_W{1'b0}}, viol_r, lock_r};
      rresp_nxt = `ROSB_RESP_OKAY;
    end
    rvalid_nxt = rvalid_r;
    if (ar_take) begin
      rvalid_nxt = 1'b1;
    end else if (rvalid_r && I_RREADY) begin
      rvalid_nxt = 1'b0;
    end
  end

  always @(posedge I_REF_CLK or negedge I_RST_B) begin
    if (!I_RST_B) begin
      arready_r <= 1'b0;
      rvalid_r  <= 1'b0;
      rdata_r   <= `ROSB_WORD_ZERO;
      rresp_r   <= `ROSB_RESP_OKAY;
    end else begin
      // one read at a time: no new address while the answer stands
      arready_r <= ~rvalid_nxt;
      rvalid_r  <= rvalid_nxt;
      if (ar_take) begin
        rdata_r <= rdata_nxt;
        rresp_r <= rresp_nxt;
      end
    end
  end

  ////////////////////////////////////////////////////////////////////////
  // outputs, all from flip-flops

  assign O_AWREADY     = awready_r;
  assign O_WREADY      = wready_r;
  assign O_BVALID      = bvalid_r;
  assign O_BRESP       = bresp_r;
  assign O_ARREADY     = arready_r;
  assign O_RVALID      = rvalid_r;
  assign O_RDATA       = rdata_r;
  assign O_RRESP       = rresp_r;
  assign O_PIN_FUNC    = code_all;
  assign O_PIN_REMAP   = remap_all;
  assign O_CONFIG_LOCK = lock_r;

endmodule // rosb_top

// [dv/rosb_props.sv]
// concurrent checks on the remap output select bank ports
`timescale 1ns/1ps
`include "rosb_map.vh"

module rosb_props #(
  parameter [31:0] P_VALID_MASK = 32'hFFFF_FFFE
) (
  input wire                                 I_REF_CLK,    // clock
  input wire                                 I_RST_B,      // reset
  input wire                                 I_ARVALID,    // read req
  input wire                                 O_ARREADY,    // read accept
  input wire                                 O_AWREADY,    // write accept
  input wire                                 O_BVALID,     // write answer
  input wire                                 O_RVALID,     // read answer
  input wire                                 I_RREADY,     // read taken
  input wire [`ROSB_DATA_W-1:0]              O_RDATA,      // read data
  input wire [`ROSB_N_SEL*`ROSB_CODE_W-1:0]  O_PIN_FUNC,   // codes
  input wire [`ROSB_N_SEL-1:0]               O_PIN_REMAP,  // remap flags
  input wire                                 O_CONFIG_LOCK // lock
);
  wire [`ROSB_N_SEL-1:0] want;
  // reserved codes must not remap, so the mask is part of the check
  for (genvar k = 0; k < `ROSB_N_SEL; k++) begin : g_want
    assign want[k] = |O_PIN_FUNC[5*k+:5] && P_VALID_MASK[O_PIN_FUNC[5*k+:5]];
  end
  ////////////////////////////////////////////////////////////////////
  default clocking cb @(posedge I_REF_CLK); endclocking
  default disable iff (!I_RST_B);
  a_reset_zero: assert property (
    $rose(I_RST_B) |-> O_PIN_FUNC == '0 && !O_CONFIG_LOCK)
    else $error("codes not clear after reset");
  a_remap_match: assert property (
    O_PIN_REMAP == want) else $error("remap flag wrong for code");
  a_lock_freeze: assert property (
    O_CONFIG_LOCK |=> $stable(O_PIN_FUNC))
    else $error("code changed while locked");
  a_pins_commit: assert property (
    !$stable(O_PIN_FUNC) |-> $rose(O_BVALID))
    else $error("code changed outside write completion");
  a_read_pad: assert property (
    O_RVALID |-> O_RDATA[31:5] == 27'h000_0000)
    else $error("upper read bits not zero");
  a_read_prompt: assert property (
    I_ARVALID && O_ARREADY |=> O_RVALID) else $error("read answer late");
  a_read_hold: assert property (
    O_RVALID && !I_RREADY |=> O_RVALID && $stable(O_RDATA))
    else $error("read data dropped");
  a_write_busy: assert property (
    $rose(O_BVALID) |-> !$past(O_AWREADY))
    else $error("address accepted before write completed");
endmodule // rosb_props

bind rosb_top rosb_props #(.P_VALID_MASK(P_VALID_MASK)) u_props (
  .I_REF_CLK(I_REF_CLK), .I_RST_B(I_RST_B), .I_ARVALID(I_ARVALID),
  .O_ARREADY(O_ARREADY), .O_AWREADY(O_AWREADY), .O_BVALID(O_BVALID),
  .O_RVALID(O_RVALID), .I_RREADY(I_RREADY), .O_RDATA(O_RDATA),
  .O_PIN_FUNC(O_PIN_FUNC), .O_PIN_REMAP(O_PIN_REMAP),
  .O_CONFIG_LOCK(O_CONFIG_LOCK));

// [dv/remap_output_select_bank_bench.sv]
// self-checking bench for the remap output select bank
`timescale 1ns/1ps
`include "rosb_map.vh"

module remap_output_select_bank_bench;
  // code 31 left reserved so the no-remap path is reached
  localparam [31:0] VMASK = 32'h7FFF_FFFE;
  localparam [11:0] IDX [14] = '{`ROSB_IDX_PIN6, `ROSB_IDX_PIN7,
    `ROSB_IDX_PIN8, `ROSB_IDX_PIN9, `ROSB_IDX_PIN10, `ROSB_IDX_PIN11,
    `ROSB_IDX_PIN12, `ROSB_IDX_PIN13, `ROSB_IDX_PIN17, `ROSB_IDX_PIN18,
    `ROSB_IDX_PIN19, `ROSB_IDX_PIN20, `ROSB_IDX_PIN21, `ROSB_IDX_PIN22};
  localparam [15:0] LOCK_A = {2'b00, `ROSB_IDX_LOCK, 2'b00};
  localparam [1:0]  OK = `ROSB_RESP_OKAY;
  localparam [1:0]  DEC = `ROSB_RESP_DEC;
  logic        clk = 1'b0;
  logic        rst_b = 1'b0;
  logic [15:0] aw_addr = 16'h0000;
  logic [15:0] ar_addr = 16'h0000;
  logic [31:0] w_data = 32'h0000_0000;
  logic [3:0]  w_strb = 4'h0;
  logic        aw_v = 1'b0;
  logic        w_v = 1'b0;
  logic        b_rdy = 1'b0;
  logic        ar_v = 1'b0;
  logic        r_rdy = 1'b0;
  wire  [1:0]  bresp;
  wire  [1:0]  rresp;
  wire  [31:0] rdata;
  wire  [69:0] pin_func;
  wire  [13:0] pin_remap;
  wire         aw_rdy;
  wire         w_rdy;
  wire         b_v;
  wire         ar_rdy;
  wire         r_v;
  wire         lock;
  int          bad_count = 0;
  int          checks_done = 0;
  wire  [1:0]  s_bresp;
  wire  [1:0]  s_rresp;
  wire  [31:0] s_rdata;
  wire  [69:0] s_pin_func;
  logic [1:0]  s_bresp_q = 2'h0;
  logic [1:0]  s_rresp_q = 2'h0;
  logic [31:0] s_rdata_q = 32'h0000_0000;
  logic [31:0] s_exp = 32'h0000_0000;

  always #2 clk = ~clk;

  rosb_top #(.P_ADDR_W(16), .P_LARGE_PKG(1), .P_VALID_MASK(VMASK)) u_dut (
    .I_REF_CLK(clk), .I_RST_B(rst_b), .I_AWADDR(aw_addr),
    .I_AWVALID(aw_v), .O_AWREADY(aw_rdy), .I_WDATA(w_data),
    .I_WSTRB(w_strb), .I_WVALID(w_v), .O_WREADY(w_rdy), .O_BRESP(bresp),
    .O_BVALID(b_v), .I_BREADY(b_rdy), .I_ARADDR(ar_addr),
    .I_ARVALID(ar_v), .O_ARREADY(ar_rdy), .O_RDATA(rdata),
    .O_RRESP(rresp), .O_RVALID(r_v), .I_RREADY(r_rdy),
    .O_PIN_FUNC(pin_func), .O_PIN_REMAP(pin_remap), .O_CONFIG_LOCK(lock));

  // the small package lacks the last four selectors; same bus timing
  rosb_top #(.P_ADDR_W(16), .P_LARGE_PKG(0), .P_VALID_MASK(VMASK))
    u_small (
    .I_REF_CLK(clk), .I_RST_B(rst_b), .I_AWADDR(aw_addr),
    .I_AWVALID(aw_v), .O_AWREADY(), .I_WDATA(w_data),
    .I_WSTRB(w_strb), .I_WVALID(w_v), .O_WREADY(), .O_BRESP(s_bresp),
    .O_BVALID(), .I_BREADY(b_rdy), .I_ARADDR(ar_addr),
    .I_ARVALID(ar_v), .O_ARREADY(), .O_RDATA(s_rdata),
    .O_RRESP(s_rresp), .O_RVALID(), .I_RREADY(r_rdy),
    .O_PIN_FUNC(s_pin_func), .O_PIN_REMAP(), .O_CONFIG_LOCK());
  ////////////////////////////////////////////////////////////////////
  task automatic check_word(input logic [31:0] got, input logic [31:0] exp);
    checks_done++;
    if (got !== exp) begin
      bad_count++;
      $display("ERROR %0t word %h expected %h", $time, got, exp);
    end
  endtask

  task automatic check_resp(input logic [1:0] got, input logic [1:0] exp);
    checks_done++;
    if (got !== exp) begin
      bad_count++;
      $display("ERROR %0t response %h expected %h", $time, got, exp);
    end
  endtask

  function automatic logic [15:0] ad(input logic [11:0] i);
    return {2'b00, i, 2'b00};
  endfunction

  task automatic wr(input logic [15:0] a, input logic [31:0] d,
                    input logic [3:0] s, input logic [1:0] er);
    aw_addr <= a;
    w_data <= d;
    w_strb <= s;
    aw_v <= 1'b1;
    w_v <= 1'b1;
    b_rdy <= 1'b1;
    do begin
      @(posedge clk);
      if (aw_v && aw_rdy) aw_v <= 1'b0;
      if (w_v && w_rdy) w_v <= 1'b0;
    end while (!(b_v && b_rdy));
    check_resp(bresp, er);
    s_bresp_q = s_bresp;
    b_rdy <= 1'b0;
    // one idle edge so ready is never dropped and raised in one step
    @(posedge clk);
  endtask

  task automatic rd(input logic [15:0] a, input logic [31:0] ed,
                    input logic [1:0] er);
    ar_addr <= a;
    ar_v <= 1'b1;
    do begin
      @(posedge clk);
      if (ar_v && ar_rdy) ar_v <= 1'b0;
      if (r_v && !r_rdy) r_rdy <= 1'b1;
    end while (!(r_v && r_rdy));
    check_word(rdata, ed);
    check_resp(rresp, er);
    s_rdata_q = s_rdata;
    s_rresp_q = s_rresp;
    r_rdy <= 1'b0;
    @(posedge clk);
  endtask

  task automatic chk_pin(input int k, input logic [4:0] c);
    check_word({27'h0, pin_func[5*k+:5]}, {27'h0, c});
    check_word({31'h0, pin_remap[k]}, {31'h0, c != 5'h00 && VMASK[c]});
  endtask

  task automatic stop_test;
    if (bad_count == 0 && checks_done > 0) begin
      $display("Testbench passed");
    end else begin
      $display("Testbench failed");
    end
    $finish;
  endtask
  ////////////////////////////////////////////////////////////////////
  initial begin
    repeat (5000) @(posedge clk);
    bad_count++;
    stop_test;
  end

  initial begin
    repeat (12) @(posedge clk);
    rst_b <= 1'b1;
    @(posedge clk);
    check_word({31'h0, lock}, 32'h0000_0000);
    for (int k = 0; k < 14; k++) begin
      chk_pin(k, 5'h00);
      rd(ad(IDX[k]), 32'h0000_0000, OK);
    end
    // upper bits set on purpose; they must not stick
    for (int k = 0; k < 14; k++) begin
      wr(ad(IDX[k]), {24'h00_0000, 3'b111, 5'(31 - k)}, 4'hF, OK);
      check_resp(s_bresp_q, (k < `ROSB_N_BASE) ? OK : DEC);
      chk_pin(k, 5'(31 - k));
      rd(ad(IDX[k]), {27'h0, 5'(31 - k)}, OK);
      check_resp(s_rresp_q, (k < `ROSB_N_BASE) ? OK : DEC);
      s_exp = (k < `ROSB_N_BASE) ? {27'h0, 5'(31 - k)} : 32'h0000_0000;
      check_word(s_rdata_q, s_exp);
      check_word({27'h0, s_pin_func[5*k+:5]}, s_exp);
    end
    wr(ad(IDX[3]), 32'h0000_0000, 4'hF, OK);
    chk_pin(3, 5'h00);
    wr(ad(IDX[1]), 32'h0000_0007, 4'h0, OK);
    chk_pin(1, 5'h1E);
    wr(LOCK_A, 32'h0000_0001, 4'hF, OK);
    check_word({31'h0, lock}, 32'h0000_0001);
    wr(ad(IDX[0]), 32'h0000_0005, 4'hF, OK);
    chk_pin(0, 5'h1F);
    rd(ad(IDX[0]), 32'h0000_001F, OK);
    rd(LOCK_A, 32'h0000_0003, OK);
    wr(LOCK_A, 32'h0000_0002, 4'hF, OK);
    rd(LOCK_A, 32'h0000_0000, OK);
    check_word({31'h0, lock}, 32'h0000_0000);
    wr(ad(IDX[0]), 32'h0000_0005, 4'hF, OK);
    chk_pin(0, 5'h05);
    rd(ad(12'hECE), 32'h0000_0000, DEC);
    wr(ad(12'hECE), 32'h0000_0001, 4'hF, DEC);
    rd(16'h0000, 32'h0000_0000, DEC);
    // lock set going into reset, so the reset must clear it too
    wr(LOCK_A, 32'h0000_0001, 4'hF, OK);
    rst_b <= 1'b0;
    repeat (2) @(posedge clk);
    rst_b <= 1'b1;
    @(posedge clk);
    for (int k = 0; k < 14; k++) chk_pin(k, 5'h00);
    check_word({31'h0, lock}, 32'h0000_0000);
    rd(ad(IDX[13]), 32'h0000_0000, OK);
    stop_test;
  end
endmodule // remap_output_select_bank_bench
